/* design/fsa_defines.svh */
// Constants shared by both ends of the program flash self-access link.
// Assumes it is included by bare name from every design file but the package.
`ifndef FSA_DEFINES_SVH
`define FSA_DEFINES_SVH

// ------------------------------------------------------------------
// Pointer, array and holding buffer geometry
// ------------------------------------------------------------------
`define FSA_PTR_W          22
`define FSA_PTR_STEP_W     21
`define FSA_MEM_AW_DEF     16
`define FSA_HOLD_BYTES     8
`define FSA_HOLD_SEL_W     3
`define FSA_ROW_SEL_LSB    6
`define FSA_ROW_WORDS      32
`define FSA_ROW_WORD_W     5
`define FSA_BLK_WORDS      4
`define FSA_BLK_WORD_W     2
`define FSA_BLANK_BYTE     8'hFF

// ------------------------------------------------------------------
// Memory control register fields and unlock keys
// ------------------------------------------------------------------
`define FSA_CTL_PGM        7
`define FSA_CTL_CFG        6
`define FSA_CTL_ERASE      4
`define FSA_CTL_WRITE_ENABLE_BIT       2
`define FSA_CTL_START      1
`define FSA_KEY_FIRST      8'h55
`define FSA_KEY_SECOND     8'hAA

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define FSA_CLK_PERIOD_NS  4
`define FSA_LONG_WRITE_NS  2000000

// ------------------------------------------------------------------
// Controller registers on AHB-Lite
// ------------------------------------------------------------------
`define FSA_REG_CMD        8'h00
`define FSA_REG_PTR        8'h04
`define FSA_REG_STAT       8'h08
`define FSA_CMD_OP_LSB     0
`define FSA_CMD_MODE_LSB   4
`define FSA_CMD_DATA_LSB   8
`define FSA_STAT_PEND      8
`define FSA_STAT_STALL     9
`define FSA_STAT_DONE      10

`endif

/* design/fsa_pkg.sv */
// Types shared by both ends of the program flash self-access link.
// Assumes nothing of its surroundings.
package fsa_pkg;

   // ------------------------------------------------------------------
   // Link operations and pointer update variants
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_TBL_RD   = 3'h0,
      OP_TBL_WR   = 3'h1,
      OP_PTR_LD   = 3'h2,
      OP_CTL_WR   = 3'h3,
      OP_CTL_RD   = 3'h4,
      OP_KEY_WR   = 3'h5,
      OP_KEY_RD   = 3'h6,
      OP_FLAG_CLR = 3'h7
   } fsa_op_e;

   typedef enum logic [1:0] {
      PTR_KEEP     = 2'h0,
      PTR_POST_INC = 2'h1,
      PTR_POST_DEC = 2'h2,
      PTR_PRE_INC  = 2'h3
   } fsa_ptr_mode_e;

   // ------------------------------------------------------------------
   // Sequencer and unlock states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_ERASE = 3'h2,
      ST_PROG  = 3'h4
   } fsa_state_e;

   typedef enum logic [2:0] {
      KEY_IDLE  = 3'h1,
      KEY_GOT1  = 3'h2,
      KEY_ARMED = 3'h4
   } fsa_key_e;

endpackage : fsa_pkg

/* design/fsa_link_if.sv */
// Link between the core-side controller and the flash self-access device.
// Assumes both ends share one clock; op_valid/op_ready is a plain handshake.
`include "fsa_defines.svh"

interface fsa_link_if;
   logic                          op_valid;
   fsa_pkg::fsa_op_e              op_kind;
   fsa_pkg::fsa_ptr_mode_e        ptr_mode;
   logic [`FSA_PTR_W-1:0]         op_data;
   logic                          op_ready;
   logic [7:0]                    rd_data;
   logic                          stall;
   logic                          done_flag;

   modport device (
      input  op_valid,
      input  op_kind,
      input  ptr_mode,
      input  op_data,
      output op_ready,
      output rd_data,
      output stall,
      output done_flag
   );

   modport host (
      output op_valid,
      output op_kind,
      output ptr_mode,
      output op_data,
      input  op_ready,
      input  rd_data,
      input  stall,
      input  done_flag
   );
endinterface : fsa_link_if

/* design/fsa_ptr_step.sv */
// Table pointer update for one table access: access address and new pointer.
// Assumes a purely combinational use; only the low step bits ever change.
`include "fsa_defines.svh"

module fsa_ptr_step #(
   parameter int PW = `FSA_PTR_W,
   parameter int SW = `FSA_PTR_STEP_W
) (
   input  wire logic [PW-1:0]           ptr_in,
   input  wire fsa_pkg::fsa_ptr_mode_e  mode,
   output logic [PW-1:0]                acc_addr,
   output logic [PW-1:0]                ptr_out
);
   wire [SW-1:0]    low_inc = ptr_in[SW-1:0] + 1'b1;
   wire [SW-1:0]    low_dec = ptr_in[SW-1:0] - 1'b1;
   wire [PW-SW-1:0] high    = ptr_in[PW-1:SW];

   always_comb begin
      acc_addr = ptr_in;
      ptr_out  = ptr_in;
      case (mode)
         fsa_pkg::PTR_KEEP: begin
            ptr_out = ptr_in;
         end
         fsa_pkg::PTR_POST_INC: begin
            ptr_out = {high, low_inc};
         end
         fsa_pkg::PTR_POST_DEC: begin
            ptr_out = {high, low_dec};
         end
         fsa_pkg::PTR_PRE_INC: begin
            acc_addr = {high, low_inc};
            ptr_out  = {high, low_inc};
         end
         default: begin
            ptr_out = ptr_in;
         end
      endcase
   end
endmodule : fsa_ptr_step

/* design/fsa_device.sv */
// Program flash self-access device: table pointer, table latch, holding
// registers, key-protected row erase and block program, self-timed.
// Assumes the core side issues one operation at a time over the link and
// halts while the stall output is high.
//
// How it works
// - Each table read returns one byte.
// - Table read loads addressed byte into latch.
// - Table read may auto-update the pointer.
// - Four pointer variants; only low 21 bits change.
// - Pointer bit zero picks word high/low byte.
// - Erase unit is one 64-byte row.
// - Self erase never covers more than one row.
// - Erase row comes from pointer bits 21:6.
// - Software loads pointer inside row before erasing.
// - Software sets program, write-enable, erase; clears config.
// - Erase or program needs the unlock keys.
// - Keys 55h, AAh, then start bit begins.
// - Core is stalled for the whole long write.
// - Internal timer ends the long write.
// - Long write lasts about two milliseconds.
// - Start bit: software sets, hardware clears.
// - Done flag set at completion, software clears.
// - Programming unit is one 8-byte block.
// - Eight byte-wide holding registers.
// - Table writes only touch holding registers.
// - Holding slot from bits 2:0, block 21:3.
// - Control write after loading starts programming.
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`include "fsa_defines.svh"

module fsa_device #(
   parameter int MEM_AW   = `FSA_MEM_AW_DEF,
   parameter int HOLD_N   = `FSA_HOLD_BYTES,
   parameter int LONG_CYC = `FSA_LONG_WRITE_NS / `FSA_CLK_PERIOD_NS
) (
   input  wire logic       CLK,
   input  wire logic       SYS_RST,
   input  wire logic       CE,
   fsa_link_if.device      LINK,
   output logic            CORE_STALL,
   output logic            WRITE_DONE_FLAG
);
   localparam int PW    = `FSA_PTR_W;
   localparam int WORDS = 2 ** (MEM_AW - 1);
   localparam int TW    = $clog2(LONG_CYC + 1);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   fsa_pkg::fsa_state_e   state_reg;
   fsa_pkg::fsa_key_e     key_reg;
   logic [TW-1:0]         timer_reg;
   logic [PW-1:0]         table_pointer_reg;
   logic [PW-1:0]         target_reg;
   logic [7:0]            table_latch_reg;
   logic [7:0]            rd_data_reg;
   logic                  program_space_select_reg;
   logic                  config_space_select_reg;
   logic                  erase_select_reg;
   logic                  write_enable_bit_reg;
   logic                  start_reg;
   logic                  write_done_flag_reg;
   logic [7:0]            hold_reg [0:HOLD_N-1];
   logic [15:0]           flash_mem [0:WORDS-1];

   // ------------------------------------------------------------------
   // Operation decode
   // ------------------------------------------------------------------
   wire       busy      = (state_reg != fsa_pkg::ST_IDLE);
   wire       take      = LINK.op_valid & LINK.op_ready;
   wire [7:0] op_byte   = LINK.op_data[7:0];
   wire       is_rd     = take & (LINK.op_kind == fsa_pkg::OP_TBL_RD);
   wire       is_wr     = take & (LINK.op_kind == fsa_pkg::OP_TBL_WR);
   wire       is_ptr_ld = take & (LINK.op_kind == fsa_pkg::OP_PTR_LD);
   wire       is_ctl_wr = take & (LINK.op_kind == fsa_pkg::OP_CTL_WR);
   wire       is_ctl_rd = take & (LINK.op_kind == fsa_pkg::OP_CTL_RD);
   wire       is_key_wr = take & (LINK.op_kind == fsa_pkg::OP_KEY_WR);
   wire       is_key_rd = take & (LINK.op_kind == fsa_pkg::OP_KEY_RD);
   wire       is_clr    = take & (LINK.op_kind == fsa_pkg::OP_FLAG_CLR);

   // A start is honoured only straight after the two keys, with program
   // space selected, configuration space off and writes enabled.
   wire start_ok = is_ctl_wr & op_byte[`FSA_CTL_START]
                 & (key_reg == fsa_pkg::KEY_ARMED)
                 & op_byte[`FSA_CTL_PGM] & ~op_byte[`FSA_CTL_CFG]
                 & op_byte[`FSA_CTL_WRITE_ENABLE_BIT];
   wire start_erase = start_ok & op_byte[`FSA_CTL_ERASE];
   wire timer_end   = busy & (timer_reg == '0);

   // ------------------------------------------------------------------
   // Pointer stepping and array read
   // ------------------------------------------------------------------
   logic [PW-1:0] acc_addr;
   logic [PW-1:0] step_ptr;

   fsa_ptr_step #(
      .PW (PW),
      .SW (`FSA_PTR_STEP_W)
   ) u_step (
      .ptr_in   (table_pointer_reg),
      .mode     (LINK.ptr_mode),
      .acc_addr (acc_addr),
      .ptr_out  (step_ptr)
   );

   wire        acc_in_range = ((acc_addr >> MEM_AW) == '0);
   wire [15:0] acc_word     = flash_mem[acc_addr[MEM_AW-1:1]];
   wire [7:0]  acc_byte     = !acc_in_range ? `FSA_BLANK_BYTE
                            : acc_addr[0]   ? acc_word[15:8]
                            :                 acc_word[7:0];
   wire        tgt_in_range = ((target_reg >> MEM_AW) == '0);

   logic [7:0] ctl_byte;

   always_comb begin
      ctl_byte                 = 8'h00;
      ctl_byte[`FSA_CTL_PGM]   = program_space_select_reg;
      ctl_byte[`FSA_CTL_CFG]   = config_space_select_reg;
      ctl_byte[`FSA_CTL_ERASE] = erase_select_reg;
      ctl_byte[`FSA_CTL_WRITE_ENABLE_BIT]  = write_enable_bit_reg;
      ctl_byte[`FSA_CTL_START] = start_reg;
   end

   // ------------------------------------------------------------------
   // Long write sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_reg  <= fsa_pkg::ST_IDLE;
         timer_reg  <= '0;
         target_reg <= '0;
      end else if (CE) begin
         case (state_reg)
            fsa_pkg::ST_IDLE: begin
               if (start_ok) begin
                  state_reg  <= start_erase ? fsa_pkg::ST_ERASE : fsa_pkg::ST_PROG;
                  timer_reg  <= TW'(LONG_CYC - 1);
                  target_reg <= table_pointer_reg;
               end
            end
            fsa_pkg::ST_ERASE, fsa_pkg::ST_PROG: begin
               if (timer_end) begin
                  state_reg <= fsa_pkg::ST_IDLE;
               end else begin
                  timer_reg <= timer_reg - 1'b1;
               end
            end
            default: begin
               state_reg <= fsa_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Memory control bits, unlock tracking, completion flag
   // ------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         program_space_select_reg <= 1'b0;
         config_space_select_reg  <= 1'b0;
         erase_select_reg         <= 1'b0;
         write_enable_bit_reg     <= 1'b0;
         start_reg                <= 1'b0;
         write_done_flag_reg      <= 1'b0;
         key_reg                  <= fsa_pkg::KEY_IDLE;
      end else if (CE) begin
         if (is_ctl_wr) begin
            program_space_select_reg <= op_byte[`FSA_CTL_PGM];
            config_space_select_reg  <= op_byte[`FSA_CTL_CFG];
            erase_select_reg         <= op_byte[`FSA_CTL_ERASE];
            write_enable_bit_reg     <= op_byte[`FSA_CTL_WRITE_ENABLE_BIT];
         end else if (timer_end && state_reg == fsa_pkg::ST_ERASE) begin
            erase_select_reg <= 1'b0;
         end
         // Software can only raise the start bit; a plain write of zero
         // cannot abort a long write half way.
         if (start_ok) begin
            start_reg <= 1'b1;
         end else if (timer_end) begin
            start_reg <= 1'b0;
         end
         // Completion wins over a clear landing in the same cycle.
         if (timer_end) begin
            write_done_flag_reg <= 1'b1;
         end else if (is_clr) begin
            write_done_flag_reg <= 1'b0;
         end
         if (is_key_wr && op_byte == `FSA_KEY_FIRST) begin
            key_reg <= fsa_pkg::KEY_GOT1;
         end else if (is_key_wr && op_byte == `FSA_KEY_SECOND
                      && key_reg == fsa_pkg::KEY_GOT1) begin
            key_reg <= fsa_pkg::KEY_ARMED;
         end else if (take) begin
            key_reg <= fsa_pkg::KEY_IDLE;
         end
      end
   end

   // ------------------------------------------------------------------
   // Table pointer, latch and read answers
   // ------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         table_pointer_reg <= '0;
         table_latch_reg   <= 8'h00;
         rd_data_reg       <= 8'h00;
      end else if (CE) begin
         if (is_ptr_ld) begin
            table_pointer_reg <= LINK.op_data;
         end else if (is_rd || is_wr) begin
            table_pointer_reg <= step_ptr;
         end
         if (is_rd) begin
            table_latch_reg <= acc_byte;
            rd_data_reg     <= acc_byte;
         end else if (is_wr) begin
            table_latch_reg <= op_byte;
         end else if (is_ctl_rd) begin
            rd_data_reg <= ctl_byte;
         end else if (is_key_rd) begin
            rd_data_reg <= 8'h00;
         end
      end
   end

   // ------------------------------------------------------------------
   // Holding registers and the array
   // ------------------------------------------------------------------
   // Holding registers have no reset: they are always reloaded before a
   // program, and the array is nonvolatile, so neither is cleared here.
   always_ff @(posedge CLK) begin
      if (CE && is_wr) begin
         hold_reg[acc_addr[`FSA_HOLD_SEL_W-1:0]] <= op_byte;
      end
   end

   always_ff @(posedge CLK) begin
      if (CE && !SYS_RST && timer_end && tgt_in_range) begin
         if (state_reg == fsa_pkg::ST_ERASE) begin
            for (int i = 0; i < `FSA_ROW_WORDS; i++) begin
               flash_mem[{target_reg[MEM_AW-1:`FSA_ROW_SEL_LSB],
                          `FSA_ROW_WORD_W'(i)}]
                  <= {`FSA_BLANK_BYTE, `FSA_BLANK_BYTE};
            end
         end else begin
            for (int j = 0; j < `FSA_BLK_WORDS; j++) begin
               flash_mem[{target_reg[MEM_AW-1:`FSA_HOLD_SEL_W],
                          `FSA_BLK_WORD_W'(j)}]
                  <= {hold_reg[2 * j + 1], hold_reg[2 * j]};
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Nothing is accepted during a long write, which is how the core halts.
   assign LINK.op_ready   = CE & ~busy;
   assign LINK.rd_data    = rd_data_reg;
   assign LINK.stall      = busy;
   assign LINK.done_flag  = write_done_flag_reg;
   assign CORE_STALL      = busy;
   assign WRITE_DONE_FLAG = write_done_flag_reg;

endmodule : fsa_device

/* design/fsa_host.sv */
// Core-side controller: takes orders over AHB-Lite and plays them onto the
// flash self-access link one operation at a time.
// Assumes a single AHB-Lite master doing whole-word single transfers.
`include "fsa_defines.svh"

module fsa_host (
   input  wire logic         CLK,
   input  wire logic         SYS_RST,
   input  wire logic         CE,
   input  wire logic         HSEL,
   input  wire logic [31:0]  HADDR,
   input  wire logic [1:0]   HTRANS,
   input  wire logic         HWRITE,
   input  wire logic [2:0]   HSIZE,
   input  wire logic [31:0]  HWDATA,
   input  wire logic         HREADY,
   output logic [31:0]       HRDATA,
   output logic              HREADYOUT,
   output logic              HRESP,
   fsa_link_if.host          LINK
);
   // ------------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------------
   logic                          dph_wr_reg;
   logic [7:0]                    dph_addr_reg;
   logic                          pend_reg;
   fsa_pkg::fsa_op_e              kind_reg;
   fsa_pkg::fsa_ptr_mode_e        mode_reg;
   logic [`FSA_PTR_W-1:0]         data_reg;
   logic [31:0]                   hrdata_reg;

   wire addr_take = HSEL & HTRANS[1] & HREADY;
   wire dph_cmd   = dph_wr_reg & (dph_addr_reg == `FSA_REG_CMD);
   wire dph_ptr   = dph_wr_reg & (dph_addr_reg == `FSA_REG_PTR);
   // A new order waits in its data phase until the previous one is taken,
   // so the bus master feels the long write as wait states.
   wire dph_block = (dph_cmd | dph_ptr) & pend_reg;
   wire wr_accept = (dph_cmd | dph_ptr) & CE & ~pend_reg;
   wire link_take = LINK.op_valid & LINK.op_ready;

   logic [31:0] stat_word;

   always_comb begin
      stat_word                  = 32'h0000_0000;
      stat_word[7:0]             = LINK.rd_data;
      stat_word[`FSA_STAT_PEND]  = pend_reg;
      stat_word[`FSA_STAT_STALL] = LINK.stall;
      stat_word[`FSA_STAT_DONE]  = LINK.done_flag;
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         dph_wr_reg   <= 1'b0;
         dph_addr_reg <= 8'h00;
         hrdata_reg   <= 32'h0000_0000;
      end else if (CE && HREADYOUT) begin
         dph_wr_reg   <= addr_take & HWRITE;
         dph_addr_reg <= HADDR[7:0];
         if (addr_take && !HWRITE) begin
            hrdata_reg <= (HADDR[7:0] == `FSA_REG_STAT) ? stat_word : 32'h0000_0000;
         end
      end
   end

   // ------------------------------------------------------------------
   // Link issue
   // ------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pend_reg <= 1'b0;
         kind_reg <= fsa_pkg::OP_TBL_RD;
         mode_reg <= fsa_pkg::PTR_KEEP;
         data_reg <= '0;
      end else if (CE) begin
         if (wr_accept) begin
            pend_reg <= 1'b1;
            if (dph_ptr) begin
               kind_reg <= fsa_pkg::OP_PTR_LD;
               data_reg <= HWDATA[`FSA_PTR_W-1:0];
            end else begin
               kind_reg <= fsa_pkg::fsa_op_e'(HWDATA[`FSA_CMD_OP_LSB +: 3]);
               mode_reg <= fsa_pkg::fsa_ptr_mode_e'(HWDATA[`FSA_CMD_MODE_LSB +: 2]);
               data_reg <= {{(`FSA_PTR_W - 8){1'b0}}, HWDATA[`FSA_CMD_DATA_LSB +: 8]};
            end
         end else if (link_take) begin
            pend_reg <= 1'b0;
         end
      end
   end

   assign HREADYOUT     = CE & ~dph_block;
   assign HRDATA        = hrdata_reg;
   assign HRESP         = 1'b0;
   assign LINK.op_valid = pend_reg;
   assign LINK.op_kind  = kind_reg;
   assign LINK.ptr_mode = mode_reg;
   assign LINK.op_data  = data_reg;

endmodule : fsa_host

/* testbench/fsa_link_checker.sv */
// Assertions on the link between the host and device ends.
// Assumes one clock, synchronous high reset and a long write of 8 to 47 cycles.
`include "fsa_defines.svh"

module fsa_link_checker (
   input wire logic                   CLK,
   input wire logic                   SYS_RST,
   input wire logic                   op_valid,
   input wire fsa_pkg::fsa_op_e       op_kind,
   input wire fsa_pkg::fsa_ptr_mode_e ptr_mode,
   input wire logic [`FSA_PTR_W-1:0]  op_data,
   input wire logic                   op_ready,
   input wire logic [7:0]             rd_data,
   input wire logic                   stall,
   input wire logic                   done_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   wire  tk     = op_valid && op_ready;
   wire  is_key = tk && op_kind == fsa_pkg::OP_KEY_WR;
   wire  is_go  = tk && op_kind == fsa_pkg::OP_CTL_WR && op_data[`FSA_CTL_START];
   wire  good   = op_data[`FSA_CTL_PGM] && !op_data[`FSA_CTL_CFG] && op_data[`FSA_CTL_WRITE_ENABLE_BIT];
   wire  is_rd  = tk && op_kind inside {fsa_pkg::OP_TBL_RD, fsa_pkg::OP_CTL_RD,
                                        fsa_pkg::OP_KEY_RD};
   logic got1_reg;
   logic armed_reg;

   // Any taken op other than the expected key breaks the sequence.
   always_ff @(posedge CLK) begin
      got1_reg  <= SYS_RST ? 1'b0 : (tk ? is_key && op_data[7:0] == 8'h55 : got1_reg);
      armed_reg <= SYS_RST ? 1'b0 : (tk ? got1_reg && is_key && op_data[7:0] == 8'hAA : armed_reg);
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   property p_stray; is_go && !armed_reg |=> !stall; endproperty
   a_stray: assert property (p_stray) else $error("start without keys");
   property p_start; is_go && armed_reg && good |=> stall; endproperty
   a_start: assert property (p_start) else $error("keyed start ignored");
   property p_busy; stall |-> !op_ready; endproperty
   a_busy: assert property (p_busy) else $error("op taken in long write");
   property p_len; $rose(stall) |-> stall[*8] ##[1:40] !stall; endproperty
   a_len: assert property (p_len) else $error("long write length");
   property p_done; $fell(stall) |-> done_flag; endproperty
   a_done: assert property (p_done) else $error("done flag not set");
   property p_hold; done_flag && !(tk && op_kind == fsa_pkg::OP_FLAG_CLR) |=> done_flag; endproperty
   a_hold: assert property (p_hold) else $error("done flag lost");
   property p_short; tk && op_kind == fsa_pkg::OP_TBL_WR |=> !stall; endproperty
   a_short: assert property (p_short) else $error("table write stalled");
   property p_latch; !is_rd |=> $stable(rd_data); endproperty
   a_latch: assert property (p_latch) else $error("latch changed");
endmodule : fsa_link_checker

/* testbench/tb_program_flash_self_access.sv */
// Bench joining host and device ends, driven over AHB-Lite.
// Assumes LONG_CYC shortened to 20 cycles.
module tb_program_flash_self_access;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
      $display("mismatch %s exp %h got %h", n, e, g); end end
   logic        CLK = 0, SYS_RST = 1, HSEL = 0, HWRITE = 0, rd_dp = 0, HREADYOUT, HRESP;
   logic [1:0]  HTRANS = 0, mir = 0;
   logic        core_stall, wdf;
   logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, r, ev, mv, rs = 32'h79AAD601;
   logic [31:0] exp_q [$], msk_q [$];
   logic [7:0]  b [8];
   int          err_total = 0, cmp_count = 0;
   fsa_link_if i_fsa_link_if ();
   fsa_host i_fsa_host (.CLK(CLK), .SYS_RST(SYS_RST), .CE(1'b1), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .LINK(i_fsa_link_if.host));
   fsa_device #(.LONG_CYC(20)) i_fsa_device (.CLK(CLK), .SYS_RST(SYS_RST), .CE(1'b1),
      .LINK(i_fsa_link_if.device), .CORE_STALL(core_stall), .WRITE_DONE_FLAG(wdf));
   fsa_link_checker i_fsa_link_checker (.CLK(CLK), .SYS_RST(SYS_RST),
      .op_valid(i_fsa_link_if.op_valid), .op_kind(i_fsa_link_if.op_kind),
      .ptr_mode(i_fsa_link_if.ptr_mode), .op_data(i_fsa_link_if.op_data),
      .op_ready(i_fsa_link_if.op_ready), .rd_data(i_fsa_link_if.rd_data),
      .stall(i_fsa_link_if.stall), .done_flag(i_fsa_link_if.done_flag));

   initial forever #2 CLK = ~CLK;

   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task report_and_stop;
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   // Single word transfer; a read notes its expectation for the monitor.
   task ahb(input logic w, input logic [31:0] a, d, e, m);
      int n;
      n = 0;
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HADDR <= a;
      HWRITE <= w;
      do begin @(posedge CLK); n++; end while (HREADYOUT !== 1'b1 && n < 500);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      if (!w) begin exp_q.push_back(e); msk_q.push_back(m); end
      do begin @(posedge CLK); n++; end while (HREADYOUT !== 1'b1 && n < 1000);
      r = HRDATA;
      if (HREADYOUT !== 1'b1) begin err_total++; report_and_stop; end
   endtask : ahb

   task op(input logic [2:0] k, input logic [1:0] md, input logic [7:0] by);
      ahb(1'b1, 32'h0, {16'h0, by, 2'b00, md, 1'b0, k}, 32'h0, 32'h0);
   endtask : op

   task ptr(input logic [21:0] p);
      ahb(1'b1, 32'h4, {10'h0, p}, 32'h0, 32'h0);
   endtask : ptr

   // Polls STAT until the given bit drops, then lets one more cycle pass.
   task poll(input int bi);
      r = 32'hFFFF;
      repeat (100) if (r[bi]) ahb(1'b0, 32'h8, 32'h0, 32'h0, 32'h0);
      if (r[bi]) begin err_total++; report_and_stop; end
      @(posedge CLK);
   endtask : poll

   task stat(input logic [31:0] e, m);
      poll(8);
      ahb(1'b0, 32'h8, 32'h0, e, m);
   endtask : stat

   task rd(input logic [1:0] md, input logic [7:0] e);
      op(3'h0, md, 8'h00);
      stat({24'h0, e}, 32'hFF);
   endtask : rd

   task unlock_go(input logic [7:0] c);
      op(3'h3, 2'h0, c);
      op(3'h5, 2'h0, 8'h55);
      op(3'h5, 2'h0, 8'hAA);
      op(3'h3, 2'h0, c | 8'h02);
      stat(32'hA00, 32'h2A00);
      poll(9);
      ahb(1'b0, 32'h8, 32'h0, 32'h1400, 32'h1E00);
   endtask : unlock_go

   always @(posedge CLK) begin
      if (rd_dp && HREADYOUT === 1'b1 && exp_q.size() > 0) begin
         ev = exp_q.pop_front();
         mv = msk_q.pop_front();
         `CHK("stat", ev, {HRDATA[31:14], HRESP, mir, HRDATA[10:0]} & mv)
      end
      // The mirrored pins are taken at the address edge, like the STAT word.
      mir <= {wdf, core_stall};
      rd_dp <= HSEL && HTRANS[1] && !HWRITE && HREADYOUT;
   end

   initial begin
      repeat (10) @(posedge CLK);
      SYS_RST <= 1'b0;
      @(posedge CLK);
      ahb(1'b0, 32'h8, 32'h0, 32'h0, 32'h3FFF);
      op(3'h3, 2'h0, 8'h84);
      op(3'h4, 2'h0, 8'h00);
      stat(32'h84, 32'hFF);
      op(3'h6, 2'h0, 8'h00);
      stat(32'h0, 32'hFF);
      op(3'h3, 2'h0, 8'h96);
      op(3'h5, 2'h0, 8'hAA);
      op(3'h5, 2'h0, 8'h55);
      op(3'h3, 2'h0, 8'h96);
      stat(32'h0, 32'hA00);
      rs = lfsr(rs);
      ptr({16'h0, rs[5:0]});
      unlock_go(8'h94);
      op(3'h7, 2'h0, 8'h00);
      stat(32'h0, 32'h1400);
      op(3'h4, 2'h0, 8'h00);
      stat(32'h84, 32'hFF);
      ptr(22'h0);
      for (int i = 0; i < 8; i++) begin
         rs = lfsr(rs);
         b[i] = rs[7:0] & 8'h7F;
         op(3'h1, 2'h1, b[i]);
      end
      ptr(22'h0);
      rd(2'h0, 8'hFF);
      ptr({19'h0, rs[10:8]});
      unlock_go(8'h84);
      ptr(22'h1FFFFF);
      rd(2'h3, b[0]);
      rd(2'h1, b[0]);
      rd(2'h2, b[1]);
      rd(2'h0, b[0]);
      ptr(22'h0);
      for (int i = 0; i < 64; i++) rd(2'h1, (i < 8) ? b[i] : 8'hFF);
      report_and_stop;
   end
endmodule : tb_program_flash_self_access
